// [hdl/mute_pkg.sv]
package mute_pkg;

  // Clock and scan timing.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_NS = 10_000_000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_500MS = 500 / 10;

  // Time settings, counted in 10 ms ticks; maximum muting time in 500 ms steps.
  localparam logic [8:0] SYNC_RST = 9'(3000 / 10);
  localparam logic [8:0] SYNC_MIN = 9'(30 / 10);
  localparam logic [8:0] SYNC_MAX = 9'(3000 / 10);
  localparam logic [5:0] DISC_RST = 6'(30 / 10);
  localparam logic [7:0] MAXMUTE_RST = 8'(60_000 / 500);

  // Register map.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIMING = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_OUTEN_LSB = 4;
  localparam int TIM_SYNC_LSB = 0;
  localparam int TIM_DISC_LSB = 12;
  localparam int TIM_MAXM_LSB = 20;
  localparam int STAT_MUTE_BIT = 6;
  localparam int STAT_OE_BIT = 7;
  localparam int STAT_STATE_LSB = 8;

  localparam logic [31:0] CTRL_MASK = 32'h0000_03ff;
  localparam logic [31:0] TIM_MASK = 32'h0ff3_f1ff;
  localparam logic [31:0] CTRL_RST = 32'h0000_03f2;
  localparam logic [31:0] TIM_RST = {4'h0, MAXMUTE_RST, 2'h0, DISC_RST, 3'h0, SYNC_RST};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_POS = 2'h0,
    MODE_PAR = 2'h1,
    MODE_SEQF = 2'h2,
    MODE_SEQB = 2'h3
  } mute_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_XWAIT = 4'h4,
    ST_MUTED = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic fault;
    logic ovr_disc;
    logic lc_disc;
    logic seq_err;
    logic sync_err;
    logic override;
  } flags_t;

endpackage

// [hdl/pair_discrepancy.sv]
`timescale 1ns/1ns
`default_nettype none
module pair_discrepancy #(
  parameter int LIMIT_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic [1:0] pair,
  input wire logic [LIMIT_W-1:0] limit,
  input wire logic run_start,
  output logic err_q
);
  logic [LIMIT_W-1:0] cnt_q;
  logic seen_off_q;
  wire mismatch = pair[0] ^ pair[1];
  wire expired = (limit != '0) && (cnt_q >= limit);
  wire rearm = seen_off_q && (pair == 2'b11);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      seen_off_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (!mismatch) cnt_q <= '0;
      else if (tick && !expired) cnt_q <= cnt_q + 1'b1;
      seen_off_q <= (pair == 2'b00) || (seen_off_q && !rearm);
      if (mismatch && expired) err_q <= 1'b1;
      else if (rearm || run_start) err_q <= 1'b0;
    end
  end
endmodule // pair_discrepancy
`default_nettype wire

// [hdl/muting_error_monitor.sv]
// Functional notes
// [R1] No synchronization error in position-detection mode.
// [R2] Entry sensors too far apart: synchronization error.
// [R3] Exit sensors too far apart: synchronization error.
// [R4] Pending error plus obstruction: output off, fault.
// [R5] Sync error alone keeps output; clears on muting.
// [R6] Position mode: obstruction without first sensor errs.
// [R7] Entry order first then second, else error.
// [R8] Early exit sensor during entry: sequence error.
// [R9] Exit order second then first exit, else error.
// [R10] Sequence valid only after all sensors off.
// [R11] Sequence error sticks until idle-to-run.
// [R12] Curtain discrepancy: output off, fault, flag.
// [R13] Override discrepancy: output off, fault, flag.
// [R14] Each status output individually enableable.
// [R15] Parallel mode mutes after first then second.
// [R16] Parallel mode ends muting when first drops; the code also ends it when the second entry sensor drops.
// [R17] Synchronization time defaults to three seconds.
// [R18] Muting starts on clean valid sequence.
// [R19] Muting stops on timeout or discrepancy.
// [R20] Synchronization time 30 ms to 3 s.
// [R21] Timing measured in whole scan cycles.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module muting_error_monitor import mute_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic first_entry_sensor,
  input wire logic second_entry_sensor,
  input wire logic first_exit_sensor,
  input wire logic second_exit_sensor,
  input wire logic [1:0] light_curtain_input,
  input wire logic [1:0] override_input,
  output logic output_enable,
  output logic muting_status,
  output flags_t status_out
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_got_q, w_got_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, ctrl_q, tim_q;
  logic [3:0] wstrb_q;
  logic [DIV_W-1:0] div_q;
  logic tick_q, run_prev_q, lc_prev_q, armed_q, ovr_q, oe_q, mute_q;
  logic sync_q, seq_q;
  logic [3:0] sens_q;
  logic [8:0] tcnt_q;
  logic [15:0] mcnt_q;
  seq_state_t st_q, st_d;
  flags_t out_q;
  logic lc_disc, ovr_disc, seq_set, sync_set;
  logic exit_dir_q, exit_dir_d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  // Register bus decode.
  wire aw_take = awvalid && awready_q;
  wire w_take = wvalid && wready_q;
  wire wr_do = aw_got_q && w_got_q && !bvalid_q;
  wire aw_got_d = (aw_got_q || aw_take) && !wr_do;
  wire w_got_d = (w_got_q || w_take) && !wr_do;
  wire ar_take = arvalid && arready_q;
  wire rvalid_d = ar_take || (rvalid_q && !rready);
  wire wr_ctrl = wr_do && (awaddr_q == REG_CTRL);
  wire wr_tim = wr_do && (awaddr_q == REG_TIMING);
  wire wr_ok = wr_ctrl || wr_tim || (awaddr_q == REG_STATUS);
  wire rd_ok = (araddr == REG_CTRL) || (araddr == REG_TIMING) || (araddr == REG_STATUS);

  // Configuration fields.
  wire run = ctrl_q[CTRL_RUN_BIT];
  wire mute_mode_t mode = mute_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  wire flags_t out_en = flags_t'(ctrl_q[CTRL_OUTEN_LSB +: 6]);
  wire [8:0] sync_raw = tim_q[TIM_SYNC_LSB +: 9];
  wire [5:0] disc_lim = tim_q[TIM_DISC_LSB +: 6];
  wire [7:0] maxm = tim_q[TIM_MAXM_LSB +: 8];
  wire [8:0] sync_eff = (sync_raw < SYNC_MIN) ? SYNC_MIN :
                        (sync_raw > SYNC_MAX) ? SYNC_MAX : sync_raw; // R20
  wire [15:0] maxm_lim = 16'(maxm) * 16'(TICKS_PER_500MS);

  // Input conditioning; every clock is one scan.
  wire [3:0] sens = {second_exit_sensor, first_exit_sensor,
                     second_entry_sensor, first_entry_sensor};
  wire [3:0] sens_m = (mode == MODE_PAR) ? (sens & 4'h3) : sens;
  wire [3:0] rise = sens_m & ~sens_q; // R21
  wire lc_on = &light_curtain_input;
  wire ovr_on = &override_input;
  wire lc_fall = lc_prev_q && !lc_on;
  wire run_start = run && !run_prev_q;
  wire seq_mode = (mode == MODE_SEQF) || (mode == MODE_SEQB);
  wire clean = !seq_q && !lc_disc && !ovr_disc;
  wire start_ok = run && clean && lc_on && oe_q; // R18
  wire sync_to = tcnt_q > sync_eff;
  wire mute_exp = (maxm != 8'h00) && (mcnt_q >= maxm_lim);
  wire entry_done = (sens & 4'h7) == 4'h0;
  wire exit_done = (sens & 4'he) == 4'h0;
  wire mute_end = (mode == MODE_POS) ? !sens[0] :
                  (mode == MODE_PAR) ? !sens[0] || !sens[1] : // R16
                  (mute_q && (st_q == ST_MUTED) && (exit_dir_q ? exit_done : entry_done));

  // Sequence checking.
  always_comb begin
    st_d = st_q;
    exit_dir_d = exit_dir_q;
    seq_set = 1'b0;
    sync_set = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (mode == MODE_POS) begin
          if (lc_fall && !sens[0]) seq_set = 1'b1; // R6
          else if (sens[0] && start_ok) st_d = ST_MUTED; // R18
        end else if (lc_fall) begin
          seq_set = 1'b1; // R7
        end else if (armed_q && (rise != 4'h0)) begin // R10
          if (rise == 4'h1) begin // R7
            st_d = ST_WAIT;
            exit_dir_d = 1'b0;
          end else if (mode == MODE_SEQB && rise == 4'h8) begin // R9
            st_d = ST_XWAIT;
            exit_dir_d = 1'b1;
          end else begin
            seq_set = 1'b1; // R7 R8 R9
          end
        end
      end
      ST_WAIT: begin
        if (lc_fall) seq_set = 1'b1; // R7
        else if (sync_to) begin
          sync_set = 1'b1; // R2
          st_d = ST_IDLE;
        end else if (seq_mode && (rise[3:2] != 2'b00)) seq_set = 1'b1; // R8
        else if (rise[1]) st_d = start_ok ? ST_MUTED : ST_IDLE; // R15
        else if (!sens[0]) st_d = ST_IDLE;
      end
      ST_XWAIT: begin
        if (lc_fall) seq_set = 1'b1; // R9
        else if (sync_to) begin
          sync_set = 1'b1; // R3
          st_d = ST_IDLE;
        end else if (rise[1:0] != 2'b00) seq_set = 1'b1; // R9
        else if (rise[2]) st_d = start_ok ? ST_MUTED : ST_IDLE; // R9
        else if (!sens[3]) st_d = ST_IDLE;
      end
      ST_MUTED: begin
        if (mute_exp || lc_disc || ovr_disc || mute_end) st_d = ST_IDLE; // R19
      end
    endcase
    if (seq_set || !run || run_start) st_d = ST_IDLE;
  end

  wire mute_enter = (st_d == ST_MUTED) && (st_q != ST_MUTED);
  wire ovr_d = run && !lc_disc && !ovr_disc && ovr_on && (sens_m != 4'h0) &&
               (ovr_q || !lc_on);
  wire pend = (sync_q || seq_q) && !lc_on;
  wire fault_d = lc_disc || ovr_disc || pend; // R4 R12 R13
  wire oe_d = run && !lc_disc && !ovr_disc && !pend &&
              (lc_on || (st_d == ST_MUTED) || ovr_d); // R4 R5 R12 R13
  wire flags_t flags_d = '{fault: fault_d, ovr_disc: ovr_disc, lc_disc: lc_disc,
                           seq_err: seq_q, sync_err: sync_q, override: ovr_q};

  pair_discrepancy #(.LIMIT_W(6)) u_lc_disc (
    .aclk(aclk), .aresetn(aresetn), .tick(tick_q), .pair(light_curtain_input),
    .limit(disc_lim), .run_start(run_start), .err_q(lc_disc) // R12
  );
  pair_discrepancy #(.LIMIT_W(6)) u_ovr_disc (
    .aclk(aclk), .aresetn(aresetn), .tick(tick_q), .pair(override_input),
    .limit(disc_lim), .run_start(run_start), .err_q(ovr_disc) // R13
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_q <= CTRL_RST;
      tim_q <= TIM_RST; // R17
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awready_q <= !aw_got_d;
      wready_q <= !w_got_d;
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (aw_take) awaddr_q <= awaddr;
      if (w_take) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) bvalid_q <= 1'b0;
      if (wr_ctrl) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & CTRL_MASK; // R14
      if (wr_tim) tim_q <= merge(tim_q, wdata_q, wstrb_q) & TIM_MASK;
      if (ar_take) begin
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= (araddr == REG_CTRL) ? ctrl_q :
                   (araddr == REG_TIMING) ? tim_q :
                   (araddr == REG_STATUS) ? {20'h00000, st_q, oe_q, mute_q, flags_d} :
                   32'h0000_0000;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
      sens_q <= 4'h0;
      lc_prev_q <= 1'b0;
      run_prev_q <= 1'b0;
      armed_q <= 1'b0;
      st_q <= ST_IDLE;
      exit_dir_q <= 1'b0;
      tcnt_q <= 9'h000;
      mcnt_q <= 16'h0000;
    end else begin
      tick_q <= div_q == DIV_W'(TICK_CYCLES - 1);
      div_q <= (div_q == DIV_W'(TICK_CYCLES - 1)) ? '0 : div_q + 1'b1;
      sens_q <= sens_m;
      lc_prev_q <= lc_on;
      run_prev_q <= run;
      armed_q <= (sens_m == 4'h0) || (armed_q && st_q == ST_IDLE && rise == 4'h0); // R10
      st_q <= st_d;
      exit_dir_q <= exit_dir_d;
      if (st_q == ST_IDLE) tcnt_q <= 9'h000;
      else if (tick_q && !sync_to) tcnt_q <= tcnt_q + 1'b1; // R2 R3
      if (st_q != ST_MUTED) mcnt_q <= 16'h0000;
      else if (tick_q && !mute_exp) mcnt_q <= mcnt_q + 1'b1; // R19
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q <= 1'b0;
      seq_q <= 1'b0;
      ovr_q <= 1'b0;
      oe_q <= 1'b0;
      mute_q <= 1'b0;
      out_q <= '0;
    end else begin
      if (sync_set && mode != MODE_POS) sync_q <= 1'b1; // R1 R2 R3
      else if (mute_enter || run_start) sync_q <= 1'b0; // R5
      if (seq_set) seq_q <= 1'b1;
      else if (run_start) seq_q <= 1'b0; // R11
      ovr_q <= ovr_d;
      oe_q <= oe_d;
      mute_q <= (st_d == ST_MUTED) || ovr_d; // R15 R18 R19
      out_q <= flags_d & out_en; // R14
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign output_enable = oe_q;
  assign muting_status = mute_q;
  assign status_out = out_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pos_no_sync: assert property ($rose(sync_q) |-> $past(mode) != MODE_POS) // R1
    else $error("sync error raised in position mode");
  a_entry_sync: assert property (st_q == ST_WAIT && sync_to && !lc_fall && run && // R2
    !run_start && mode != MODE_POS |=> sync_q)
    else $error("entry sync timeout missed");
  a_exit_sync: assert property (st_q == ST_XWAIT && sync_to && !lc_fall && run && // R3
    !run_start && mode != MODE_POS |=> sync_q && st_q == ST_IDLE)
    else $error("exit sync timeout missed");
  a_pend_fault: assert property ((sync_q || seq_q) && !lc_on // R4
    |=> !oe_q && out_q.fault == $past(out_en.fault))
    else $error("pending error did not force safe state");
  a_sync_alone: assert property (sync_q && !seq_q && lc_on && !lc_disc && !ovr_disc && // R5
    run |=> oe_q && !out_q.fault)
    else $error("sync error alone dropped output");
  a_pos_seq: assert property (mode == MODE_POS && st_q == ST_IDLE && lc_fall && // R6
    !sens[0] && run && !run_start |=> seq_q)
    else $error("position sequence error missed");
  a_same_cycle: assert property (mode != MODE_POS && st_q == ST_IDLE && armed_q && // R7
    run && !run_start && !lc_fall && rise[1:0] == 2'b11 |=> seq_q)
    else $error("simultaneous entry not flagged");
  a_seq_sticky: assert property (seq_q && !run_start |=> seq_q) // R11
    else $error("sequence error cleared early");
  a_lc_disc: assert property (lc_disc |=> !oe_q && out_q.fault == $past(out_en.fault)) // R12
    else $error("curtain discrepancy not safe");
  a_ovr_disc: assert property (ovr_disc // R13
    |=> (!oe_q && out_q.fault == $past(out_en.fault)) ##1 (!oe_q || !ovr_disc))
    else $error("override discrepancy not safe");
  a_par_end: assert property (mode == MODE_PAR && st_q == ST_MUTED && !sens[0] // R16
    |=> st_q == ST_IDLE)
    else $error("parallel muting did not end");
  a_out_gate: assert property (##1 status_out == $past(flags_d & out_en)) // R14
    else $error("status gating wrong");

  c_muted: cover property (st_q == ST_WAIT ##1 st_q == ST_MUTED);
  c_exit_muted: cover property (st_q == ST_XWAIT ##1 st_q == ST_MUTED);
  c_sync_clear: cover property (sync_q ##[1:1000] !sync_q);
endmodule // muting_error_monitor
`default_nettype wire

// [tb/sensor_model.sv]
`timescale 1ns/1ns
`default_nettype none
module sensor_model (
  input wire logic aclk,
  input wire logic [3:0] sens_cmd,
  input wire logic [1:0] lc_cmd,
  input wire logic [1:0] ovr_cmd,
  output logic [3:0] sens,
  output logic [1:0] lc,
  output logic [1:0] ovr
);
  // Field devices start quiet with the curtain clear.
  initial begin
    sens = 4'h0;
    lc = 2'h3;
    ovr = 2'h0;
  end
  // Levels move once per scan, just after the clock edge.
  always @(posedge aclk) begin
    sens <= sens_cmd;
    lc <= lc_cmd;
    ovr <= ovr_cmd;
  end
endmodule // sensor_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_top import mute_pkg::*; ;
  localparam int TK = 4;
  localparam int LIMIT = 20000;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  typedef struct {
    string nm;
    logic [31:0] v;
    logic [31:0] m;
    logic [1:0] r;
  } note_t;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic [3:0] sens_cmd;
  logic [3:0] sens;
  logic [1:0] lc_cmd;
  logic [1:0] lc;
  logic [1:0] ovr_cmd;
  logic [1:0] ovr;
  logic output_enable;
  logic muting_status;
  flags_t status_out;
  note_t notes[$];
  note_t cur;
  int n_checks;
  int mismatches;
  int cycles;
  int i;

  sensor_model i_model (.aclk(aclk), .sens_cmd(sens_cmd), .lc_cmd(lc_cmd),
    .ovr_cmd(ovr_cmd), .sens(sens), .lc(lc), .ovr(ovr));

  muting_error_monitor #(.TICK_CYCLES(TK)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .first_entry_sensor(sens[0]), .second_entry_sensor(sens[1]),
    .first_exit_sensor(sens[2]), .second_exit_sensor(sens[3]),
    .light_curtain_input(lc), .override_input(ovr), .output_enable(output_enable),
    .muting_status(muting_status), .status_out(status_out));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    notes.push_back('{"bresp", 32'h0, 32'h0, r});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
    @(posedge aclk);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] v,
    input logic [31:0] m, input logic [1:0] r);
    notes.push_back('{nm, v, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) rready <= 1'b0;
    end while (arvalid || rready);
    @(posedge aclk);
  endtask

  // Status byte is {output enable, muting, flags}.
  task automatic st(input string nm, input logic [7:0] v, input logic [7:0] m);
    rd(nm, REG_STATUS, {24'h0, v}, {24'h0, m}, RESP_OKAY);
  endtask

  task automatic sn(input logic [3:0] s, input int n);
    sens_cmd <= s;
    repeat (n) @(posedge aclk);
  endtask

  task automatic cw(input logic [1:0] l, input logic [1:0] o, input int n);
    lc_cmd <= l;
    ovr_cmd <= o;
    repeat (n) @(posedge aclk);
  endtask

  // Idle then run, all outputs enabled.
  task automatic go(input logic [1:0] md);
    wr(REG_CTRL, {22'h0, 6'h3f, 1'b0, md, 1'b0}, RESP_OKAY);
    wr(REG_CTRL, {22'h0, 6'h3f, 1'b0, md, 1'b1}, RESP_OKAY);
  endtask

  always @(posedge aclk) begin
    if ((rvalid === 1'b1 && rready) || (bvalid === 1'b1 && bready)) begin
      cur = notes.pop_front();
      if (bvalid === 1'b1) begin
        `CHK(cur.nm, cur.r, bresp)
      end else begin
        `CHK(cur.nm, {cur.r, cur.v & cur.m}, {rresp, rdata & cur.m})
      end
    end
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    n_checks = 0;
    mismatches = 0;
    aresetn = 1'b0;
    awaddr = 8'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    sens_cmd = 4'h0;
    lc_cmd = 2'h3;
    ovr_cmd = 2'h0;
    void'($urandom(84586));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd("ctrl", REG_CTRL, CTRL_RST, ALL, RESP_OKAY);
    rd("timing", REG_TIMING, TIM_RST, ALL, RESP_OKAY);
    rd("hole", 8'h0c, 32'h0, ALL, RESP_SLVERR);
    wr(8'h0c, 32'h0, RESP_SLVERR);
    wr(REG_STATUS, $urandom, RESP_OKAY);
    st("idle", 8'h00, 8'hc0);
    wr(REG_TIMING, 32'h0000_2001, RESP_OKAY);
    rd("sync_min", REG_TIMING, 32'h0000_2001, ALL, RESP_OKAY);
    wr(REG_TIMING, 32'h0000_2190, RESP_OKAY);
    rd("sync_max", REG_TIMING, 32'h0000_2190, ALL, RESP_OKAY);
    wstrb <= 4'h1;
    wr(REG_TIMING, 32'h0fff_ff01, RESP_OKAY);
    wstrb <= 4'hf;
    rd("strobe", REG_TIMING, 32'h0000_2101, ALL, RESP_OKAY);
    wr(REG_TIMING, 32'h0000_2001, RESP_OKAY);
    go(MODE_PAR);
    st("run", 8'h80, 8'hff);
    sn(4'h1, 1 + int'($urandom % 4));
    sn(4'h3, 4);
    st("muted", 8'hc0, 8'hff);
    `CHK("mute_pin", 1'b1, muting_status)
    cw(2'h0, 2'h0, 4);
    st("muted_dark", 8'hc0, 8'hff);
    cw(2'h3, 2'h0, 4);
    sn(4'h2, 4);
    st("mute_end", 8'h80, 8'hff);
    sn(4'h0, 4);
    sn(4'h1, 40);
    sn(4'h0, 4);
    st("sync", 8'h82, 8'ha2);
    sn(4'h1, 2);
    sn(4'h3, 4);
    st("sync_clr", 8'hc0, 8'hc2);
    sn(4'h0, 4);
    cw(2'h0, 2'h0, 4);
    st("dark", 8'h24, 8'ha4);
    cw(2'h3, 2'h0, 4);
    sn(4'h1, 2);
    sn(4'h3, 4);
    st("stuck", 8'h04, 8'h44);
    sn(4'h0, 4);
    go(MODE_PAR);
    st("cleared", 8'h80, 8'hff);
    for (i = 0; i < 2; i++) begin
      sn(4'h2 | 4'(i), 2);
      sn(4'h3, 4);
      st("order", 8'h04, 8'h44);
      sn(4'h0, 4);
      go(MODE_PAR);
    end
    for (i = 0; i < 2; i++) begin
      go(i == 0 ? MODE_SEQF : MODE_SEQB);
      sn(4'h4, 2);
      sn(4'h5, 2);
      sn(4'h7, 4);
      st("early_exit", 8'h04, 8'h44);
      sn(4'h0, 4);
    end
    go(MODE_SEQB);
    sn(4'h8, 2);
    sn(4'hc, 4);
    st("exit_mute", 8'hc0, 8'hff);
    sn(4'h0, 4);
    sn(4'h8, 40);
    sn(4'h0, 4);
    st("exit_sync", 8'h02, 8'h06);
    sn(4'h4, 2);
    sn(4'hc, 4);
    st("exit_order", 8'h04, 8'h44);
    sn(4'h0, 4);
    go(MODE_POS);
    sn(4'h1, 40);
    sn(4'h3, 4);
    sn(4'h0, 4);
    st("pos_sync", 8'h00, 8'h02);
    cw(2'h0, 2'h0, 4);
    st("pos_dark", 8'h24, 8'ha4);
    cw(2'h3, 2'h0, 4);
    go(MODE_PAR);
    cw(2'h2, 2'h0, 20);
    st("lc_disc", 8'h28, 8'ha8);
    wr(REG_CTRL, 32'h0000_0083, RESP_OKAY);
    cw(2'h2, 2'h0, 2);
    `CHK("pin_en", 6'h08, status_out)
    `CHK("pin_oe", 1'b0, output_enable)
    wr(REG_CTRL, 32'h0000_0003, RESP_OKAY);
    cw(2'h2, 2'h0, 2);
    `CHK("pin_dis", 6'h00, status_out)
    cw(2'h0, 2'h0, 4);
    cw(2'h3, 2'h0, 4);
    st("lc_clr", 8'h00, 8'h08);
    go(MODE_PAR);
    cw(2'h3, 2'h1, 20);
    st("ovr_disc", 8'h30, 8'hb0);
    cw(2'h3, 2'h0, 4);
    cw(2'h3, 2'h3, 4);
    st("ovr_clr", 8'h00, 8'h10);
    cw(2'h3, 2'h0, 4);
    wr(REG_TIMING, 32'h0010_2003, RESP_OKAY);
    go(MODE_PAR);
    sn(4'h1, 2);
    sn(4'h3, 4);
    st("mute_long", 8'h40, 8'h40);
    repeat (220) @(posedge aclk);
    st("max_mute", 8'h00, 8'h40);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
